//--- rtl/cpu_flag_register_logic.sv
// processor flag register with its update logic and software access port
`timescale 1ns/1ps
`include "cpu_flags_regs.svh"

// Behaviour
// RL1 - eight-bit register with fixed flag positions
// RL2 - software writes never touch system flags
// RL3 - expiry flag: time-out sets, instructions clear
// RL4 - sleep flag: sleep sets, refresh clears
// RL5 - arithmetic flags follow latest affecting operation
// RL6 - carry from add, no-borrow, rotate shift
// RL7 - half carry out of low nibble
// RL8 - zero flag marks all-zero result
// RL9 - overflow when carries in and out differ
// RL10 - signed compare is overflow xor result msb
// RL11 - chained zero copies zero on subtract
// RL12 - no automatic save of flags anywhere
// RL13 - borrow subtract ands chained zero with zero
// RL14 - system flags zero after power-on reset
module cpu_flag_register_logic (
   input logic sys_clk,
   input logic srst,
   input logic ce,
   input logic op_valid,
   input cpu_flags_pkg::alu_op_type op_kind,
   input cpu_flags_pkg::byte_type op_a,
   input cpu_flags_pkg::byte_type op_b,
   input logic wdt_timeout,
   input logic wdt_refresh_exec,
   input logic sleep_exec,
   input logic [7:0] reg_addr,
   input cpu_flags_pkg::byte_type reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output cpu_flags_pkg::byte_type reg_rdata,
   output cpu_flags_pkg::byte_type result_out,
   output cpu_flags_pkg::byte_type cpu_flags_out
);
   import cpu_flags_pkg::*;

   byte_type arith_r;
   byte_type arith_nxt;
   byte_type result_r;
   byte_type rdata_r;
   byte_type rdata_nxt;
   byte_type alu_res;
   byte_type fresh;
   byte_type mask;
   byte_type flags_view;
   logic alu_c;
   logic alu_ac;
   logic alu_ov;
   logic alu_z;
   logic to_flag;
   logic pdf_flag;
   logic wr_flags;

   // which flags a given operation refreshes
   function automatic byte_type upd_mask(input alu_op_type op);
      byte_type m;
      m = `MASK_NONE;
      unique case (op)
         OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW: m = `MASK_ARITH;
         OP_AND, OP_OR, OP_XOR: m = `MASK_LOGIC;
         OP_ROT_LEFT_C, OP_ROT_RIGHT_C: m = `MASK_ROTATE;
         default: m = `MASK_NONE;
      endcase
      return m;
   endfunction : upd_mask

   // carries of add-with-carry, borrow subtract and rotates come from the
   // stored carry flag, so multi-byte sequences chain without help
   flag_alu u_alu (
      .op(op_kind),
      .a(op_a),
      .b(op_b),
      .cin(arith_r[`FLG_C]),
      .res(alu_res),
      .c(alu_c),
      .ac(alu_ac),
      .ov(alu_ov),
      .z(alu_z)
   );

   sys_flag_ctrl u_sys (
      .sys_clk(sys_clk),
      .srst(srst),
      .ce(ce),
      .wdt_timeout(wdt_timeout),
      .wdt_refresh_exec(wdt_refresh_exec),
      .sleep_exec(sleep_exec),
      .watchdog_expiry_flag(to_flag),
      .sleep_entered_flag(pdf_flag)
   );

   assign wr_flags = reg_wr && (reg_addr == `CPU_FLAGS_OFS);

   // fresh flag values packed at their register positions
   always_comb begin
      fresh = `FLAGS_RESET;
      fresh[`FLG_SC] = alu_ov ^ alu_res[7]; // RL10
      fresh[`FLG_OV] = alu_ov; // RL9
      fresh[`FLG_Z] = alu_z; // RL8
      fresh[`FLG_AC] = alu_ac; // RL7
      fresh[`FLG_C] = alu_c; // RL6
   end

   // next arithmetic flags; a software write in the same cycle as an
   // operation wins, since it is the later intent of the program
   always_comb begin
      arith_nxt = arith_r;
      mask = upd_mask(op_kind);
      if (op_valid) begin
         arith_nxt = (arith_r & ~mask) | (fresh & mask); // RL5
         if (op_kind == OP_SUB) begin
            arith_nxt[`FLG_CZ] = alu_z; // RL11
         end else if (op_kind == OP_SUB_BORROW) begin
            arith_nxt[`FLG_CZ] = arith_r[`FLG_CZ] & alu_z; // RL13
         end
      end
      if (wr_flags) begin
         arith_nxt = reg_wdata & `FLAGS_WR_MASK; // RL2
      end
   end

   // arithmetic flag storage; power-on value is a defined zero, although
   // software may not rely on it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         arith_r <= `FLAGS_RESET; // RL14
      end else if (ce) begin
         arith_r <= arith_nxt;
      end
   end

   // last operation result, kept for the datapath and for software
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         result_r <= `RESULT_RESET;
      end else if (ce && op_valid) begin
         result_r <= alu_res;
      end
   end

   // the full register view; nothing here pushes it anywhere on calls or
   // interrupt entry, saving it is the program's job
   always_comb begin
      flags_view = arith_r & `FLAGS_WR_MASK;
      flags_view[`FLG_TO] = to_flag; // RL1
      flags_view[`FLG_PDF] = pdf_flag; // RL1
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata_nxt = `RDATA_RESET;
      if (reg_addr == `CPU_FLAGS_OFS) begin
         rdata_nxt = flags_view;
      end else if (reg_addr == `LAST_RESULT_OFS) begin
         rdata_nxt = result_r;
      end
   end

   // read data appear in the cycle after the strobe and only then
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_r <= `RDATA_RESET;
      end else if (ce) begin
         rdata_r <= reg_rd ? rdata_nxt : `RDATA_RESET;
      end
   end

   assign reg_rdata = rdata_r;
   assign result_out = result_r;
   assign cpu_flags_out = flags_view; // RL12

   // ---- checks ----
   logic [8:0] chk_sum9;
   logic [4:0] chk_lo;
   logic [7:0] chk_low7;
   logic plain_add;
   logic arith_op;

   assign chk_sum9 = {1'b0, op_a} + {1'b0, op_b};
   assign chk_lo = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
   assign chk_low7 = {1'b0, op_a[6:0]} + {1'b0, op_b[6:0]};
   assign plain_add = ce && op_valid && !wr_flags && (op_kind == OP_ADD);
   assign arith_op = ce && op_valid && !wr_flags && (upd_mask(op_kind) == `MASK_ARITH);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_sys_after_reset;
      srst |=> !cpu_flags_out[`FLG_TO] && !cpu_flags_out[`FLG_PDF];
   endproperty
   a_sys_after_reset: assert property (disable iff (1'b0) p_sys_after_reset)
      else $error("system flags not zero after reset"); // RL14

   property p_write_keeps_sys;
      ce && wr_flags && !wdt_timeout && !wdt_refresh_exec && !sleep_exec
         |=> $stable(cpu_flags_out[5:4]) &&
             (cpu_flags_out & `FLAGS_WR_MASK) == ($past(reg_wdata) & `FLAGS_WR_MASK);
   endproperty
   a_write_keeps_sys: assert property (p_write_keeps_sys)
      else $error("software write disturbed system flags"); // RL2

   property p_add_carry;
      plain_add |=> cpu_flags_out[`FLG_C] == $past(chk_sum9[8]);
   endproperty
   a_add_carry: assert property (p_add_carry)
      else $error("carry wrong after add"); // RL6

   property p_rotate_left;
      ce && op_valid && !wr_flags && op_kind == OP_ROT_LEFT_C
         |=> cpu_flags_out[`FLG_C] == $past(op_a[7]) &&
             result_out[0] == $past(cpu_flags_out[`FLG_C]);
   endproperty
   a_rotate_left: assert property (p_rotate_left)
      else $error("rotate left did not pass through carry"); // RL6

   property p_half_carry;
      plain_add |=> cpu_flags_out[`FLG_AC] == $past(chk_lo[4]);
   endproperty
   a_half_carry: assert property (p_half_carry)
      else $error("half carry wrong after add"); // RL7

   property p_zero;
      ce && op_valid && !wr_flags && upd_mask(op_kind) != `MASK_ROTATE && op_kind != OP_NONE
         |=> cpu_flags_out[`FLG_Z] == (result_out == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag disagrees with result"); // RL8

   property p_overflow;
      plain_add |=> cpu_flags_out[`FLG_OV] == ($past(chk_low7[7]) ^ $past(chk_sum9[8]));
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow wrong after add"); // RL9

   property p_signed_cmp;
      arith_op |=> cpu_flags_out[`FLG_SC] == (cpu_flags_out[`FLG_OV] ^ result_out[7]);
   endproperty
   a_signed_cmp: assert property (p_signed_cmp)
      else $error("signed compare not overflow xor msb"); // RL10

   property p_cz_sub;
      ce && op_valid && !wr_flags && op_kind == OP_SUB
         |=> cpu_flags_out[`FLG_CZ] == cpu_flags_out[`FLG_Z];
   endproperty
   a_cz_sub: assert property (p_cz_sub) else $error("chained zero not equal to zero"); // RL11

   property p_cz_other;
      ce && op_valid && !wr_flags && op_kind != OP_SUB && op_kind != OP_SUB_BORROW
         |=> $stable(cpu_flags_out[`FLG_CZ]);
   endproperty
   a_cz_other: assert property (p_cz_other)
      else $error("chained zero changed by a non-subtract"); // RL11

   property p_cz_borrow;
      ce && op_valid && !wr_flags && op_kind == OP_SUB_BORROW
         |=> cpu_flags_out[`FLG_CZ] ==
             ($past(cpu_flags_out[`FLG_CZ]) && cpu_flags_out[`FLG_Z]);
   endproperty
   a_cz_borrow: assert property (p_cz_borrow)
      else $error("chained zero not combined on borrow subtract"); // RL13

   property p_hold;
      ce && !op_valid && !reg_wr |=> $stable(cpu_flags_out & `FLAGS_WR_MASK);
   endproperty
   a_hold: assert property (p_hold) else $error("flags moved with no operation"); // RL5

   property p_read_flags;
      ce && reg_rd && reg_addr == `CPU_FLAGS_OFS |=> reg_rdata == $past(cpu_flags_out)
         ##1 (reg_rdata == 8'h00 || $past(reg_rd));
   endproperty
   a_read_flags: assert property (p_read_flags) else $error("flag read data wrong"); // RL1

   c_borrow_chain: cover property (
      ce && op_valid && op_kind == OP_SUB ##1 ce && op_valid && op_kind == OP_SUB_BORROW);
   c_timeout: cover property (ce && wdt_timeout ##1 cpu_flags_out[`FLG_TO]);
   c_sleep: cover property (ce && sleep_exec ##1 cpu_flags_out[`FLG_PDF]);
   c_flag_write: cover property (ce && wr_flags ##1 ce && reg_rd);

endmodule : cpu_flag_register_logic

//--- rtl/cpu_flags_regs.svh
// register offsets, flag bit positions, masks and reset values of the flag block
`ifndef CPU_FLAGS_REGS_SVH
`define CPU_FLAGS_REGS_SVH

// register offsets on the software port
`define CPU_FLAGS_OFS 8'h00
`define LAST_RESULT_OFS 8'h01

// flag bit positions inside the flag register
`define FLG_SC 7
`define FLG_CZ 6
`define FLG_TO 5
`define FLG_PDF 4
`define FLG_OV 3
`define FLG_Z 2
`define FLG_AC 1
`define FLG_C 0

// bits that a software write may change (the two system flags excluded)
`define FLAGS_WR_MASK 8'hcf
// flags refreshed by each class of operation (chained zero handled apart)
`define MASK_ARITH 8'h8f
`define MASK_LOGIC 8'h04
`define MASK_ROTATE 8'h01
`define MASK_NONE 8'h00

// reset values
`define FLAGS_RESET 8'h00
`define RESULT_RESET 8'h00
`define RDATA_RESET 8'h00

`endif

//--- rtl/cpu_flags_pkg.sv
// types shared by the flag register block
package cpu_flags_pkg;

   // operation reported by the execution unit
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD = 4'h1,
      OP_ADD_CARRY = 4'h2,
      OP_SUB = 4'h3,
      OP_SUB_BORROW = 4'h4,
      OP_AND = 4'h5,
      OP_OR = 4'h6,
      OP_XOR = 4'h7,
      OP_ROT_LEFT_C = 4'h8,
      OP_ROT_RIGHT_C = 4'h9
   } alu_op_type;

   typedef logic [7:0] byte_type;

endpackage : cpu_flags_pkg

//--- rtl/flag_alu.sv
// combinational datapath that yields an operation result and its raw flags
`timescale 1ns/1ps
module flag_alu (
   input cpu_flags_pkg::alu_op_type op,
   input cpu_flags_pkg::byte_type a,
   input cpu_flags_pkg::byte_type b,
   input logic cin,
   output cpu_flags_pkg::byte_type res,
   output logic c,
   output logic ac,
   output logic ov,
   output logic z
);
   import cpu_flags_pkg::*;

   byte_type bx;
   logic ci;
   logic [4:0] lo_sum;
   logic [7:0] low7_sum;
   logic [8:0] sum9;

   // subtraction is a + ~b + carry, so carry out means no borrow
   always_comb begin
      bx = b;
      ci = 1'b0;
      unique case (op)
         OP_ADD_CARRY: ci = cin;
         OP_SUB: begin
            bx = ~b;
            ci = 1'b1;
         end
         OP_SUB_BORROW: begin
            bx = ~b;
            ci = cin;
         end
         default: ci = 1'b0;
      endcase
   end

   assign lo_sum = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
   assign low7_sum = {1'b0, a[6:0]} + {1'b0, bx[6:0]} + {7'h00, ci};
   assign sum9 = {1'b0, a} + {1'b0, bx} + {8'h00, ci};

   // result and carry per operation; rotates pass through the carry
   always_comb begin
      res = sum9[7:0];
      c = sum9[8]; // RL6
      unique case (op)
         OP_AND: res = a & b;
         OP_OR: res = a | b;
         OP_XOR: res = a ^ b;
         OP_ROT_LEFT_C: begin
            res = {a[6:0], cin};
            c = a[7]; // RL6
         end
         OP_ROT_RIGHT_C: begin
            res = {cin, a[7:1]};
            c = a[0]; // RL6
         end
         default: res = sum9[7:0];
      endcase
   end

   assign ac = lo_sum[4]; // RL7
   assign ov = low7_sum[7] ^ sum9[8]; // RL9
   assign z = (res == 8'h00); // RL8

endmodule : flag_alu

//--- rtl/sys_flag_ctrl.sv
// watchdog expiry and sleep entered flags, cleared by power-up only through srst
`timescale 1ns/1ps
module sys_flag_ctrl (
   input logic sys_clk,
   input logic srst,
   input logic ce,
   input logic wdt_timeout,
   input logic wdt_refresh_exec,
   input logic sleep_exec,
   output logic watchdog_expiry_flag,
   output logic sleep_entered_flag
);
   logic to_r;
   logic pdf_r;

   // a time-out in the same cycle as a clearing instruction wins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         to_r <= 1'b0; // RL14
      end else if (ce) begin
         if (wdt_timeout) begin
            to_r <= 1'b1; // RL3
         end else if (wdt_refresh_exec || sleep_exec) begin
            to_r <= 1'b0; // RL3
         end
      end
   end

   // sleep sets, refresh clears; nothing else, software writes included
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pdf_r <= 1'b0; // RL14
      end else if (ce) begin
         if (sleep_exec) begin
            pdf_r <= 1'b1; // RL4
         end else if (wdt_refresh_exec) begin
            pdf_r <= 1'b0; // RL4
         end
      end
   end

   assign watchdog_expiry_flag = to_r;
   assign sleep_entered_flag = pdf_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_to_hold;
      ce && !wdt_timeout && !wdt_refresh_exec && !sleep_exec |=> $stable(to_r);
   endproperty
   a_to_hold: assert property (p_to_hold) else $error("expiry flag moved without cause"); // RL3

   property p_to_clear;
      ce && !wdt_timeout && (wdt_refresh_exec || sleep_exec) |=> !to_r;
   endproperty
   a_to_clear: assert property (p_to_clear) else $error("expiry flag not cleared"); // RL3

   property p_pdf_track;
      ce && (sleep_exec || wdt_refresh_exec) |=> pdf_r == $past(sleep_exec);
   endproperty
   a_pdf_track: assert property (p_pdf_track) else $error("sleep flag wrong"); // RL4

endmodule : sys_flag_ctrl

//--- bench/exec_unit_model.sv
// behavioural execution unit, decoder and watchdog that drive the flag block
`timescale 1ns/1ps
module exec_unit_model (
   input logic sys_clk,
   output logic op_valid,
   output cpu_flags_pkg::alu_op_type op_kind,
   output cpu_flags_pkg::byte_type op_a,
   output cpu_flags_pkg::byte_type op_b,
   output logic wdt_timeout,
   output logic wdt_refresh_exec,
   output logic sleep_exec
);
   import cpu_flags_pkg::*;

   // idle at time zero
   initial begin
      op_valid = 1'b0;
      op_kind = OP_NONE;
      op_a = 8'h00;
      op_b = 8'h00;
      {wdt_timeout, wdt_refresh_exec, sleep_exec} = 3'b000;
   end

   // one completed operation; operands are inverted afterwards so stale values never look valid
   task automatic run_op(input alu_op_type k, input byte_type a, input byte_type b);
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_a <= a;
      op_b <= b;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      op_a <= ~a;
      op_b <= ~b;
   endtask : run_op

   // one-cycle system event pulse, ev is {time-out, refresh, sleep}
   task automatic pulse(input logic [2:0] ev);
      @(posedge sys_clk);
      {wdt_timeout, wdt_refresh_exec, sleep_exec} <= ev;
      @(posedge sys_clk);
      {wdt_timeout, wdt_refresh_exec, sleep_exec} <= 3'b000;
   endtask : pulse
endmodule : exec_unit_model

//--- bench/cpu_flag_register_logic_tb.sv
// self-checking bench for the flag register block
`timescale 1ns/1ps
`include "cpu_flags_regs.svh"
module cpu_flag_register_logic_tb;
   import cpu_flags_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic op_valid;
   logic wdt_timeout;
   logic wdt_refresh_exec;
   logic sleep_exec;
   alu_op_type op_kind;
   byte_type op_a;
   byte_type op_b;
   byte_type reg_wdata = 8'h00;
   byte_type reg_rdata;
   byte_type result_out;
   byte_type cpu_flags_out;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   int errors = 0;
   int check_count = 0;
   // {op, a, b, result, flags}; carry-in of each line is the carry left by the line before
   logic [35:0] ops [15] = '{
      36'h1_ff_01_00_47, 36'h1_7f_01_80_4a, 36'h4_03_01_01_03, 36'h4_02_02_00_07,
      36'h3_05_05_00_47, 36'h4_00_00_00_47, 36'h3_80_01_7f_89, 36'h3_01_02_ff_80,
      36'h5_0f_f0_00_84, 36'h6_0f_f0_ff_80, 36'h7_ff_ff_00_84, 36'h8_80_00_00_85,
      36'h9_02_00_81_84, 36'h8_80_00_00_85, 36'h2_0e_01_10_02};

   always #4 sys_clk = ~sys_clk;

   cpu_flag_register_logic cpu_flag_register_logic_i (
      .sys_clk(sys_clk), .srst(srst), .ce(ce), .op_valid(op_valid), .op_kind(op_kind),
      .op_a(op_a), .op_b(op_b), .wdt_timeout(wdt_timeout),
      .wdt_refresh_exec(wdt_refresh_exec), .sleep_exec(sleep_exec), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .result_out(result_out), .cpu_flags_out(cpu_flags_out));

   exec_unit_model exec_unit_model_i (
      .sys_clk(sys_clk), .op_valid(op_valid), .op_kind(op_kind), .op_a(op_a), .op_b(op_b),
      .wdt_timeout(wdt_timeout), .wdt_refresh_exec(wdt_refresh_exec),
      .sleep_exec(sleep_exec));

   task automatic check(input string name, input byte_type seen, input byte_type exp);
      check_count++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         errors++;
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic reg_write(input logic [7:0] addr, input byte_type data);
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // data stand only in the cycle after the strobe, zero the cycle after that
   task automatic reg_read(input logic [7:0] addr, input byte_type exp, input string name);
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(name, reg_rdata, exp);
      @(posedge sys_clk);
      #1;
      check("rdata_idle", reg_rdata, 8'h00);
   endtask : reg_read

   task automatic chk_flags(input byte_type exp);
      reg_read(`CPU_FLAGS_OFS, exp, "flags_read");
      check("flags_out", cpu_flags_out, exp);
   endtask : chk_flags

   task automatic step(input logic [35:0] t);
      exec_unit_model_i.run_op(alu_op_type'(t[35:32]), t[31:24], t[23:16]);
      #1;
      check("result_out", result_out, t[15:8]);
      chk_flags(t[7:0]);
   endtask : step

   // hang guard, far beyond the roughly 133 cycles the sequence needs
   initial begin
      #20000;
      errors++;
      $display("watchdog expired");
      end_of_test();
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      chk_flags(8'h00);
      reg_read(8'h05, 8'h00, "unmapped");
      reg_write(`CPU_FLAGS_OFS, 8'hff);
      chk_flags(8'hcf);
      // a write while the clock enable is low must be lost
      @(posedge sys_clk);
      ce <= 1'b0;
      reg_write(`CPU_FLAGS_OFS, 8'h00);
      ce <= 1'b1;
      chk_flags(8'hcf);
      foreach (ops[i]) begin
         step(ops[i]);
      end
      reg_read(`LAST_RESULT_OFS, 8'h10, "last_result");
      reg_write(`LAST_RESULT_OFS, 8'hff);
      reg_read(`LAST_RESULT_OFS, 8'h10, "last_result_ro");
      exec_unit_model_i.pulse(3'b001);
      chk_flags(8'h12);
      exec_unit_model_i.pulse(3'b100);
      chk_flags(8'h32);
      reg_write(`CPU_FLAGS_OFS, 8'h00);
      chk_flags(8'h30);
      exec_unit_model_i.pulse(3'b010);
      chk_flags(8'h00);
      exec_unit_model_i.pulse(3'b100);
      exec_unit_model_i.pulse(3'b001);
      chk_flags(8'h10);
      end_of_test();
   end
endmodule : cpu_flag_register_logic_tb
